// >>> core/erl_byte_ram.v
// Byte-wide single-port memory holding one log sector.
// Assumes one writer or reader per cycle; read data is registered.
`timescale 1ns/1ps
`default_nettype none

module erl_byte_ram #(
  parameter AW = 9,
  parameter DW = 8
) (
  input  wire          pclk,
  input  wire          we,
  input  wire [AW-1:0] addr,
  input  wire [DW-1:0] wdata,
  output reg  [DW-1:0] rdata
);

  reg [DW-1:0] mem [0:(1<<AW)-1];

  // ****************************************************
  // Write and registered read
  // ****************************************************
  always @(posedge pclk)
  begin
    if (we)
      mem[addr] <= wdata;
    rdata <= mem[addr];
  end

endmodule
`default_nettype wire

// >>> core/erl_pair_reg.v
// Task file field shadow: latest written value and the value before it.
// Assumes a one-cycle write strobe from the same clock domain.
`timescale 1ns/1ps
`default_nettype none

module erl_pair_reg #(
  parameter W = 8
) (
  input  wire         pclk,
  input  wire         presetn,
  input  wire         wr,
  input  wire [W-1:0] din,
  output reg  [W-1:0] cur_r,
  output reg  [W-1:0] prev_r
);

  // Shift on every write, old current becomes previous
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cur_r  <= {W{1'b0}};
      prev_r <= {W{1'b0}};
    end
    else if (wr)
    begin
      prev_r <= cur_r;
      cur_r  <= din;
    end
  end

endmodule
`default_nettype wire

// >>> core/erl_recorder.v
// Error and self-test log sector recorder with an APB register port.
// Assumes a single 100 MHz clock; software feeds task file writes and events.
//
// Summary of operation
// - Four error slots used as a ring; fifth error reuses slot one.
// - Error slots never written read back as zero bytes.
// - Error entry: five 18-byte command snapshots then a 34-byte error snapshot.
// - Command snapshot: control, paired fields, device/head, opcode, reserved, ms stamp.
// - Low byte is latest host write, high byte the value before it.
// - Error snapshot: error, paired fields, device/head, status, vendor, state, hours.
// - Error low byte is current value, high byte the previous value.
// - State code low nibble 0-4 defined, 5-A reserved, B-F vendor.
// - Error counter ignores rejected commands.
// - Error counter saturates at maximum while logging continues.
// - Eighteen 26-byte self-test slots used as a ring.
// - Self-test slots never written read back as zero bytes.
// - Self-test sector revision byte reads 01h.
// - Self-test index points at newest slot, zero when none, 0 to 18.
// - Self-test sector layout: revision, index, descriptors, vendor, checksum.
// - Descriptor: number, status, hours, checkpoint, 48-bit address, vendor bytes.
// - Self-test log holds both 48-bit and 28-bit addressed results.
// - Error index points at newest slot, zero when none, 0 to 4.
// - Error sector version byte reads 01h.
`timescale 1ns/1ps
`default_nettype none
`include "erl_regs.vh"

module erl_recorder #(
  parameter [16:0] MS_CYCLES = `ERL_MS_CYCLES
) (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr
);

  localparam [1:0] S_INIT = 2'h0;
  localparam [1:0] S_IDLE = 2'h1;
  localparam [1:0] S_RD   = 2'h2;
  localparam [1:0] S_WR   = 2'h3;
  localparam [16:0] MS_LAST = MS_CYCLES - 17'h00001;

  reg  [1:0]   state_r;
  reg  [8:0]   ptr_r;
  reg  [8:0]   base_r;
  reg          kind_r;
  reg  [2:0]   eidx_r;
  reg  [4:0]   sidx_r;
  reg  [15:0]  ecnt_r;
  reg  [7:0]   esum_r;
  reg  [7:0]   ssum_r;
  reg  [16:0]  presc_r;
  reg  [31:0]  ts_r;
  reg  [7:0]   devctl_r;
  reg  [7:0]   devhead_r;
  reg  [719:0] hist_r;
  reg  [31:0]  einfo_r;
  reg  [15:0]  hours_r;
  reg  [24:0]  sinfo_r;
  reg  [47:0]  slba_r;
  reg  [9:0]   laddr_r;
  wire [39:0]  tf_cur;
  wire [39:0]  tf_prev;
  wire [991:0] err_ent;
  wire [207:0] st_ent;
  wire [7:0]   eram_q;
  wire [7:0]   sram_q;
  wire [7:0]   new_byte;
  wire [7:0]   old_byte;
  wire [8:0]   ram_addr;
  wire         busy;
  wire         acc;
  wire         fire;
  wire         tf_we;
  wire [143:0] snap;
  wire [7:0]   state_code;
  wire [47:0]  lba_st;
  wire [7:0]   ram_byte;
  reg  [31:0]  rd_nxt;
  reg          err_nxt;
  wire [4:0]   eidx_nxt;

  // ****************************************************
  // Helper functions
  // ****************************************************
  // Next ring slot, 1-based, wrapping after the last
  function [4:0] ring_next;
    input [4:0] idx;
    input [4:0] last;
    begin
      ring_next = (idx == last) ? 5'h01 : idx + 5'h01;
    end
  endfunction

  // Sector byte address of a 1-based slot
  function [8:0] slot_base;
    input [4:0] slot;
    input [8:0] len;
    reg   [8:0] m1;
    begin
      m1        = {4'h0, slot} - 9'h001;
      slot_base = `ERL_ENT_BASE + m1 * len;
    end
  endfunction

  assign busy = (state_r != S_IDLE);
  assign eidx_nxt = ring_next({2'b00, eidx_r}, {2'b00, `ERL_ERR_SLOTS});
  assign acc  = psel & penable;
  assign fire = acc & pready & !pslverr;
  assign tf_we = fire & pwrite & (paddr == `ERL_OFS_TF_WR);

  // ****************************************************
  // Task file shadows and command history
  // ****************************************************
  genvar g;
  generate
    for (g = 0; g < 5; g = g + 1)
    begin : g_pair
      erl_pair_reg #(.W(8)) u_pair (
        .pclk    (pclk),
        .presetn (presetn),
        .wr      (tf_we & (pwdata[10:8] == g)),
        .din     (pwdata[7:0]),
        .cur_r   (tf_cur[g*8 +: 8]),
        .prev_r  (tf_prev[g*8 +: 8])
      );
    end
  endgenerate

  // Command snapshot, first byte in the low bits
  assign snap = {ts_r, 8'h00, pwdata[7:0], devhead_r,
                 tf_prev[39:32], tf_cur[39:32], tf_prev[31:24], tf_cur[31:24],
                 tf_prev[23:16], tf_cur[23:16], tf_prev[15:8], tf_cur[15:8],
                 tf_prev[7:0], tf_cur[7:0], devctl_r};

  // Control, device/head bytes and the five-deep history
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      devctl_r  <= `ERL_RST_BYTE;
      devhead_r <= `ERL_RST_BYTE;
      hist_r    <= {720{1'b0}};
    end
    else if (tf_we)
    begin
      if (pwdata[10:8] == `ERL_TF_DEVCTL)
        devctl_r <= pwdata[7:0];
      if (pwdata[10:8] == `ERL_TF_DEVHEAD)
        devhead_r <= pwdata[7:0];
      if (pwdata[10:8] == `ERL_TF_COMMAND)
        hist_r <= {snap, hist_r[719:144]};
    end
  end

  // ****************************************************
  // Entry images
  // ****************************************************
  // Reserved low nibbles fold to unknown
  assign state_code = (einfo_r[27:24] > 4'h4 && einfo_r[27:24] < 4'hb) ?
                      {einfo_r[31:28], 4'h0} : einfo_r[31:24];

  assign err_ent = {hours_r, state_code, 152'h0, einfo_r[15:8], devhead_r,
                    tf_prev[39:32], tf_cur[39:32], tf_prev[31:24], tf_cur[31:24],
                    tf_prev[23:16], tf_cur[23:16], tf_prev[15:8], tf_cur[15:8],
                    einfo_r[7:0], 8'h00, hist_r};

  assign lba_st = sinfo_r[`ERL_ST_ADDR28] ? {20'h00000, slba_r[27:0]} : slba_r;
  assign st_ent = {120'h0, lba_st, sinfo_r[23:16], hours_r,
                   sinfo_r[15:8], sinfo_r[7:0]};

  // ****************************************************
  // Sector memories
  // ****************************************************
  assign ram_addr = busy ? (base_r + ptr_r) : laddr_r[8:0];
  assign new_byte = (state_r == S_INIT) ? 8'h00 :
                    kind_r ? st_ent[{ptr_r[4:0], 3'b000} +: 8] :
                    err_ent[{ptr_r[6:0], 3'b000} +: 8];
  assign old_byte = kind_r ? sram_q : eram_q;

  erl_byte_ram #(.AW(9), .DW(8)) u_eram (
    .pclk  (pclk),
    .we    ((state_r == S_INIT) | (state_r == S_WR && !kind_r)),
    .addr  (ram_addr),
    .wdata (new_byte),
    .rdata (eram_q)
  );

  erl_byte_ram #(.AW(9), .DW(8)) u_sram (
    .pclk  (pclk),
    .we    ((state_r == S_INIT) | (state_r == S_WR && kind_r)),
    .addr  (ram_addr),
    .wdata (new_byte),
    .rdata (sram_q)
  );

  // ****************************************************
  // Millisecond power-on timestamp
  // ****************************************************
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      presc_r <= 17'h00000;
      ts_r    <= `ERL_RST_WORD;
    end
    else if (presc_r == MS_LAST)
    begin
      presc_r <= 17'h00000;
      ts_r    <= ts_r + 32'h00000001;
    end
    else
      presc_r <= presc_r + 17'h00001;
  end

  // ****************************************************
  // Entry writer: clear pass, then read-old / write-new per byte
  // ****************************************************
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_r <= S_INIT;
      ptr_r   <= 9'h000;
      base_r  <= 9'h000;
      kind_r  <= 1'b0;
      eidx_r  <= 3'h0;
      sidx_r  <= 5'h00;
      ecnt_r  <= 16'h0000;
      esum_r  <= 8'h00;
      ssum_r  <= 8'h00;
    end
    else
    begin
      case (state_r)
        S_INIT:
        begin
          ptr_r <= ptr_r + 9'h001;
          if (ptr_r == 9'h1ff)
          begin
            ptr_r   <= 9'h000;
            state_r <= S_IDLE;
          end
        end
        S_IDLE:
        begin
          if (fire && pwrite && paddr == `ERL_OFS_CTRL)
          begin
            if (pwdata[`ERL_CTRL_LOG_ERR] && !pwdata[`ERL_CTRL_REJECTED])
            begin
              eidx_r  <= eidx_nxt[2:0];
              base_r  <= slot_base(eidx_nxt, `ERL_ERR_LEN);
              if (ecnt_r != 16'hffff)
                ecnt_r <= ecnt_r + 16'h0001;
              kind_r  <= 1'b0;
              state_r <= S_RD;
            end
            else if (pwdata[`ERL_CTRL_LOG_ST])
            begin
              sidx_r  <= ring_next(sidx_r, `ERL_ST_SLOTS);
              base_r  <= slot_base(ring_next(sidx_r, `ERL_ST_SLOTS), `ERL_ST_LEN);
              kind_r  <= 1'b1;
              state_r <= S_RD;
            end
          end
        end
        S_RD:
          state_r <= S_WR;
        S_WR:
        begin
          // Running sums keep the checksum current
          if (kind_r)
            ssum_r <= ssum_r + new_byte - old_byte;
          else
            esum_r <= esum_r + new_byte - old_byte;
          ptr_r   <= ptr_r + 9'h001;
          state_r <= S_RD;
          if (ptr_r == (kind_r ? `ERL_ST_LEN : `ERL_ERR_LEN) - 9'h001)
          begin
            ptr_r   <= 9'h000;
            state_r <= S_IDLE;
          end
        end
        default:
          state_r <= S_IDLE;
      endcase
    end
  end

  // ****************************************************
  // Software staging registers and log read pointer
  // ****************************************************
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      einfo_r <= `ERL_RST_WORD;
      hours_r <= 16'h0000;
      sinfo_r <= 25'h0000000;
      slba_r  <= 48'h000000000000;
      laddr_r <= 10'h000;
    end
    else if (fire && pwrite)
    begin
      case (paddr)
        `ERL_OFS_ERR_INFO:  einfo_r <= pwdata;
        `ERL_OFS_HOURS:     hours_r <= pwdata[15:0];
        `ERL_OFS_ST_INFO:   sinfo_r <= pwdata[24:0];
        `ERL_OFS_ST_LBA_LO: slba_r[31:0] <= pwdata;
        `ERL_OFS_ST_LBA_HI: slba_r[47:32] <= pwdata[15:0];
        `ERL_OFS_LOG_ADDR:  laddr_r <= pwdata[9:0];
        default:            laddr_r <= laddr_r;
      endcase
    end
    else if (fire && paddr == `ERL_OFS_LOG_DATA)
      laddr_r[8:0] <= laddr_r[8:0] + 9'h001;
  end

  // ****************************************************
  // Sector read view: fixed header bytes, counter, checksum
  // ****************************************************
  assign ram_byte = laddr_r[9] ? sram_q : eram_q;

  always @*
  begin
    rd_nxt  = `ERL_RST_WORD;
    err_nxt = 1'b0;
    case (paddr)
      `ERL_OFS_CTRL:      rd_nxt = {31'h0, busy};
      `ERL_OFS_STATUS:    rd_nxt = {ecnt_r, 3'h0, sidx_r, 5'h00, eidx_r};
      `ERL_OFS_TF_WR:     rd_nxt = `ERL_RST_WORD;
      `ERL_OFS_ERR_INFO:  rd_nxt = einfo_r;
      `ERL_OFS_HOURS:     rd_nxt = {16'h0000, hours_r};
      `ERL_OFS_ST_INFO:   rd_nxt = {7'h00, sinfo_r};
      `ERL_OFS_ST_LBA_LO: rd_nxt = slba_r[31:0];
      `ERL_OFS_ST_LBA_HI: rd_nxt = {16'h0000, slba_r[47:32]};
      `ERL_OFS_LOG_ADDR:  rd_nxt = {22'h000000, laddr_r};
      `ERL_OFS_LOG_DATA:
      begin
        err_nxt = busy & !pwrite;
        if (laddr_r[8:0] == 9'h000)
          rd_nxt = {24'h0, `ERL_VERSION};
        else if (laddr_r[8:0] == `ERL_ADR_IDX_LO)
          rd_nxt = laddr_r[9] ? {27'h0, sidx_r} : {29'h0, eidx_r};
        else if (laddr_r[8:0] == `ERL_ADR_CNT_LO && !laddr_r[9])
          rd_nxt = {24'h0, ecnt_r[7:0]};
        else if (laddr_r[8:0] == `ERL_ADR_CNT_HI && !laddr_r[9])
          rd_nxt = {24'h0, ecnt_r[15:8]};
        else if (laddr_r[8:0] == `ERL_ADR_CHECKSUM)
          rd_nxt = laddr_r[9] ?
                   {24'h0, 8'h00 - (`ERL_VERSION + {3'h0, sidx_r} + ssum_r)} :
                   {24'h0, 8'h00 - (`ERL_VERSION + {5'h00, eidx_r} + ecnt_r[7:0]
                                    + ecnt_r[15:8] + esum_r)};
        else
          rd_nxt = {24'h0, ram_byte};
      end
      default:            err_nxt = 1'b1;
    endcase
    // Writes other than the read pointer get an error while the writer is busy
    if (pwrite && busy && paddr != `ERL_OFS_LOG_ADDR)
      err_nxt = 1'b1;
  end

  // ****************************************************
  // APB answer: one wait state, outputs from flops
  // ****************************************************
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= `ERL_RST_WORD;
    end
    else
    begin
      pready <= acc & !pready;
      if (acc && !pready)
      begin
        pslverr <= err_nxt;
        prdata  <= (pwrite || err_nxt) ? `ERL_RST_WORD : rd_nxt;
      end
      else
      begin
        pslverr <= 1'b0;
        prdata  <= `ERL_RST_WORD;
      end
    end
  end

endmodule
`default_nettype wire

// >>> core/erl_recorder_dummy_guard.v
`timescale 1ns/1ps

// >>> core/erl_regs.vh
// Register offsets, field positions, reset values and timing for the log recorder.
// Assumes inclusion by bare name from design files; definitions only.
`ifndef ERL_REGS_VH
`define ERL_REGS_VH

// APB register offsets (byte addresses)
`define ERL_OFS_CTRL      8'h00
`define ERL_OFS_STATUS    8'h04
`define ERL_OFS_TF_WR     8'h08
`define ERL_OFS_ERR_INFO  8'h0c
`define ERL_OFS_HOURS     8'h10
`define ERL_OFS_ST_INFO   8'h14
`define ERL_OFS_ST_LBA_LO 8'h18
`define ERL_OFS_ST_LBA_HI 8'h1c
`define ERL_OFS_LOG_ADDR  8'h20
`define ERL_OFS_LOG_DATA  8'h24

// Control register bits, plus the 28-bit address flag of the self-test info register
`define ERL_CTRL_LOG_ERR  0
`define ERL_CTRL_REJECTED 1
`define ERL_CTRL_LOG_ST   2
`define ERL_ST_ADDR28     24

// Task file field selects written through TF_WR
`define ERL_TF_DEVCTL     3'h5
`define ERL_TF_DEVHEAD    3'h6
`define ERL_TF_COMMAND    3'h7

// Sector layout
`define ERL_VERSION       8'h01
`define ERL_ERR_SLOTS     3'h4
`define ERL_ST_SLOTS      5'h12
`define ERL_ERR_LEN       9'h07c
`define ERL_ST_LEN        9'h01a
`define ERL_ENT_BASE      9'h004
`define ERL_ADR_IDX_LO    9'h002
`define ERL_ADR_CNT_LO    9'h1f4
`define ERL_ADR_CNT_HI    9'h1f5
`define ERL_ADR_CHECKSUM  9'h1ff

// Reset values
`define ERL_RST_WORD      32'h00000000
`define ERL_RST_BYTE      8'h00

// Timestamp timing: one millisecond at a 10 ns clock
`define ERL_MS_NS         1000000
`define ERL_CLK_NS        10
`define ERL_MS_CYCLES     17'h186a0

`endif

// >>> testbench/erl_host_model.sv
// Host controller model: APB master that issues register and log reads.
// Assumes one clock shared with the recorder; callers enter xfer at any time.
`timescale 1ns/1ps
`default_nettype none

module erl_host_model (
  input  wire logic        pclk,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr,
  output var  logic        psel,
  output var  logic        penable,
  output var  logic        pwrite,
  output var  logic [7:0]  paddr,
  output var  logic [31:0] pwdata,
  output var  logic        stuck
);
  // ********************
  // Bus idle at start
  // ********************
  initial
  begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    stuck = 1'b0;
  end

  // One transfer: setup, access held until pready, then release
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 40);
    q = prdata;
    e = pslverr;
    if (n >= 40)
      stuck <= 1'b1;
    psel <= 1'b0;
    penable <= 1'b0;
    // Released lines show no stale value
    paddr <= ~a;
    pwdata <= ~d;
  endtask
endmodule
`default_nettype wire

// >>> testbench/erl_recorder_assertions.sv
// Checker for the recorder's APB answers and sector header read-back.
// Assumes binding to erl_recorder; sees its ports only.
`timescale 1ns/1ps
`default_nettype none
`include "erl_regs.vh"

module erl_recorder_assertions #(
  parameter [16:0] MS_CYCLES = 17'd10
) (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr
);
  // ********************
  // Helper tracking
  // ********************
  logic [9:0]  log_addr_r;
  logic [15:0] cnt_r;
  wire done_ok = psel && penable && pready && !pslverr;
  wire rd_log = done_ok && !pwrite && (paddr == `ERL_OFS_LOG_DATA);
  wire rd_stat = done_ok && !pwrite && (paddr == `ERL_OFS_STATUS);

  // Mirror of the sector pointer and last count read
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      log_addr_r <= 10'h000;
      cnt_r <= 16'h0000;
    end
    else
    begin
      if (done_ok && pwrite && paddr == `ERL_OFS_LOG_ADDR)
        log_addr_r <= pwdata[9:0];
      else if (rd_log)
        log_addr_r[8:0] <= log_addr_r[8:0] + 9'h001;
      if (rd_stat)
        cnt_r <= prdata[31:16];
    end

  // ********************
  // Properties
  // ********************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_answer;
    !pready ##1 pready;
  endsequence

  a_one_wait: assert property (s_setup |=> s_answer)
    else $error("pready not in second access cycle");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready held longer than one cycle");
  a_idle_quiet: assert property (!pready |-> (prdata == 32'h0 && !pslverr))
    else $error("read data or error outside answer cycle");
  a_err_version: assert property (rd_log && log_addr_r == 10'h000 |-> prdata[7:0] == 8'h01)
    else $error("error sector version wrong");
  a_st_revision: assert property (rd_log && log_addr_r == 10'h200 |-> prdata[7:0] == 8'h01)
    else $error("self-test sector revision wrong");
  a_err_index_top: assert property (rd_log && log_addr_r == 10'h002 |-> prdata[7:0] <= 8'h04)
    else $error("error index out of range");
  a_st_index_top: assert property (rd_log && log_addr_r == 10'h202 |-> prdata[7:0] <= 8'h12)
    else $error("self-test index out of range");
  a_index_high_zero: assert property (rd_log && log_addr_r[8:0] == 9'h003 |-> prdata[7:0] == 8'h00)
    else $error("index high byte not zero");
  a_status_range: assert property (rd_stat |-> prdata[2:0] <= 3'h4 && prdata[12:8] <= 5'h12)
    else $error("status index out of range");
  a_count_no_drop: assert property (rd_stat |-> prdata[31:16] >= cnt_r)
    else $error("error count went down");
endmodule

bind erl_recorder erl_recorder_assertions #(.MS_CYCLES(MS_CYCLES)) i_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
`default_nettype wire

// >>> testbench/tb_top.sv
// Self-checking bench for the log recorder, driven through the host model.
// Assumes a short millisecond tick; sectors read back byte by byte.
`timescale 1ns/1ps
`default_nettype none
`include "erl_regs.vh"

module tb_top;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel, penable, pwrite, pready, pslverr, stuck;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata;
  logic [7:0]  sec [0:511];
  int          fail_count = 0;
  int          tests_run = 0;

  // ********************
  // Clock, models, design
  // ********************
  always #5 pclk = ~pclk;
  erl_host_model i_host (.pclk(pclk), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .stuck(stuck));
  erl_recorder #(.MS_CYCLES(17'd10)) i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr));

  // ********************
  // Shared tasks
  // ********************
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic        e;
    i_host.xfer(1'b1, a, d, q, e);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    logic e;
    i_host.xfer(1'b0, a, 32'h0, q, e);
  endtask
  task automatic tf(input logic [2:0] f, input logic [7:0] b);
    wr(`ERL_OFS_TF_WR, {21'h0, f, b});
  endtask
  task automatic wait_idle;
    logic [31:0] q;
    int          n;
    n = 0;
    do
    begin
      rd(`ERL_OFS_CTRL, q);
      n++;
    end
    while (q[0] !== 1'b0 && n < 400);
    if (n >= 400)
    begin
      fail_count++;
      report_and_stop();
    end
  endtask
  // Whole sector into sec, with the zero-sum check
  task automatic rd_sector(input logic sel);
    logic [31:0] q;
    logic [7:0]  sum;
    sum = 8'h00;
    wr(`ERL_OFS_LOG_ADDR, {22'h0, sel, 9'h000});
    for (int i = 0; i < 512; i++)
    begin
      rd(`ERL_OFS_LOG_DATA, q);
      sec[i] = q[7:0];
      sum = sum + q[7:0];
    end
    chk("sector_sum", sum, 8'h00);
  endtask

  // ********************
  // Scenarios
  // ********************
  task automatic t_empty;
    logic [31:0] q;
    logic [7:0]  acc;
    rd(`ERL_OFS_STATUS, q);
    chk("status_empty", q, 32'h0);
    for (int s = 0; s < 2; s++)
    begin
      acc = 8'h00;
      rd_sector(s[0]);
      chk("version", sec[0], 8'h01);
      for (int i = 1; i < 511; i++)
        acc = acc | sec[i];
      chk("unused_zero", acc, 8'h00);
      chk("checksum_empty", sec[511], 8'hff);
    end
  endtask
  task automatic t_err_entry;
    tf(3'h0, 8'ha1);
    tf(3'h0, 8'hb2);
    tf(3'h1, 8'h11);
    tf(3'h1, 8'h22);
    tf(`ERL_TF_DEVCTL, 8'h00);
    tf(`ERL_TF_DEVHEAD, 8'he0);
    for (int k = 0; k < 5; k++)
      tf(`ERL_TF_COMMAND, 8'h20 + 8'(k));
    wr(`ERL_OFS_ERR_INFO, 32'h04005104);
    wr(`ERL_OFS_HOURS, 32'h00001234);
    wr(`ERL_OFS_CTRL, 32'h1);
    wait_idle();
    rd_sector(1'b0);
    chk("err_index", sec[2], 8'h01);
    chk("err_count", {sec[9'h1f5], sec[9'h1f4]}, 16'h0001);
    for (int k = 0; k < 5; k++)
      chk("cmd_opcode", sec[16 + 18 * k], 8'h20 + 8'(k));
    chk("cmd_devctl", sec[4], 8'h00);
    chk("cmd_feature", {sec[6], sec[5]}, 16'ha1b2);
    chk("cmd_count", {sec[8], sec[7]}, 16'h1122);
    chk("cmd_devhead", sec[15], 8'he0);
    chk("cmd_stamp", {sec[93], sec[92], sec[91], sec[90]} > {sec[21], sec[20], sec[19], sec[18]}, 1'b1);
    chk("err_byte", sec[8'h5f], 8'h04);
    chk("err_count_pair", {sec[8'h61], sec[8'h60]}, 16'h1122);
    chk("err_devhead", sec[8'h68], 8'he0);
    chk("err_status", sec[8'h69], 8'h51);
    chk("err_state", sec[8'h7d], 8'h04);
    chk("err_hours", {sec[8'h7f], sec[8'h7e]}, 16'h1234);
  endtask
  task automatic t_rejected;
    logic [31:0] q;
    wr(`ERL_OFS_CTRL, 32'h3);
    wait_idle();
    rd(`ERL_OFS_STATUS, q);
    chk("status_rejected", q, 32'h00010001);
  endtask
  task automatic t_ring;
    logic [31:0] q;
    logic [7:0]  st [4] = '{8'h01, 8'h02, 8'h03, 8'h37};
    for (int j = 0; j < 4; j++)
    begin
      wr(`ERL_OFS_ERR_INFO, {st[j], 8'h00, 8'h51, 8'h40 + 8'(j)});
      wr(`ERL_OFS_CTRL, 32'h1);
      wait_idle();
    end
    rd(`ERL_OFS_STATUS, q);
    chk("status_wrap", q, 32'h00050001);
    rd_sector(1'b0);
    chk("slot1_reused", sec[8'h5f], 8'h43);
    chk("state_reserved", sec[8'h7d], 8'h30);
    for (int s = 1; s < 4; s++)
      chk("state_code", sec[4 + 124 * s + 8'h79], st[s - 1]);
  endtask
  task automatic t_selftest;
    logic [31:0] q;
    logic [47:0] logical_block_address;
    logical_block_address = 48'h9abc12345678;
    wr(`ERL_OFS_ST_LBA_LO, logical_block_address[31:0]);
    wr(`ERL_OFS_ST_LBA_HI, {16'h0, logical_block_address[47:32]});
    for (int n = 1; n < 20; n++)
    begin
      wr(`ERL_OFS_ST_INFO, {7'h0, n == 2, 8'hc0, 8'h07, 8'(n)});
      wr(`ERL_OFS_CTRL, 32'h4);
      wait_idle();
      rd(`ERL_OFS_STATUS, q);
      chk("st_index", q[12:8], (n == 19) ? 5'h01 : 5'(n));
    end
    rd_sector(1'b1);
    chk("st_idx_byte", {sec[3], sec[2]}, 16'h0001);
    chk("st_slot1", sec[4], 8'h13);
    chk("st_slot2", sec[8'h1e], 8'h02);
    chk("st_status", sec[8'h39], 8'h07);
    chk("st_hours", {sec[8'h3b], sec[8'h3a]}, 16'h1234);
    chk("st_check", sec[8'h3c], 8'hc0);
    for (int b = 0; b < 6; b++)
    begin
      chk("lba48", sec[8'h3d + b], logical_block_address[8 * b +: 8]);
      chk("lba28", sec[8'h23 + b], {20'h0, logical_block_address[27:0]} >> (8 * b) & 48'hff);
    end
  endtask
  task automatic t_bad_addr;
    logic [31:0] q;
    logic        e;
    i_host.xfer(1'b0, 8'h30, 32'h0, q, e);
    chk("unmapped_err", e, 1'b1);
    chk("unmapped_data", q, 32'h0);
  endtask

  // ********************
  // Main sequence and hang guard
  // ********************
  always @(posedge stuck)
  begin
    fail_count++;
    report_and_stop();
  end
  initial
  begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    wait_idle();
    t_empty();
    t_err_entry();
    t_rejected();
    t_ring();
    t_selftest();
    t_bad_addr();
    report_and_stop();
  end
endmodule
`default_nettype wire
